// ---- design/scbfe_front_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module scbfe_front_end
  import scbfe_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 CE,
  input  wire logic                 CKE,
  input  wire logic                 CS_N,
  input  wire logic                 RAS_N,
  input  wire logic                 CAS_N,
  input  wire logic                 WE_N,
  input  wire logic [BA_W-1:0]      BA,
  input  wire logic [ADDR_W-1:0]    ADDR,
  input  wire logic                 DQS_T_IN,
  input  wire logic                 DQS_C_IN,
  input  wire logic [DQ_W-1:0]      DQ_RISE_IN,
  input  wire logic [DQ_W-1:0]      DQ_FALL_IN,
  input  wire logic                 BURST_LEN_8,
  input  wire logic                 BURST_INTERLEAVE,
  input  wire logic [CL_W-1:0]      CAS_LATENCY,
  input  wire logic [1:0]           ADD_LAT_SEL,
  input  wire logic [DQ_W-1:0]      ARR_RDATA_RISE,
  input  wire logic [DQ_W-1:0]      ARR_RDATA_FALL,
  output logic                      ARR_RD,
  output logic                      ARR_WR,
  output logic [BA_W-1:0]           ARR_BANK,
  output logic [COL_W-1:0]          ARR_COL_RISE,
  output logic [COL_W-1:0]          ARR_COL_FALL,
  output logic [DQ_W-1:0]           ARR_WDATA_RISE,
  output logic [DQ_W-1:0]           ARR_WDATA_FALL,
  output logic [DQ_W-1:0]           DQ_RISE_OUT,
  output logic [DQ_W-1:0]           DQ_FALL_OUT,
  output logic                      DQ_OE_N,
  output logic                      DQS_T_OUT,
  output logic                      DQS_C_OUT,
  output logic                      DQS_OE_N,
  output logic [NUM_BANKS-1:0]      BANK_ACTIVE,
  output logic                      POWER_DOWN,
  output logic                      SELF_REFRESH,
  output logic                      CLK_STOPPED
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic scbfe_cmd_t decode(input scbfe_pins_t s);
    if (s.cs_n) return CMD_NOP;
    case ({s.ras_n, s.cas_n, s.we_n})
      3'b011:  return CMD_ACT;
      3'b010:  return CMD_PRE;
      3'b101:  return CMD_RD;
      3'b100:  return CMD_WR;
      3'b001:  return CMD_REF;
      3'b111:  return CMD_NOP;
      default: return CMD_OTHER;
    endcase
  endfunction

  // Low three column bits of word idx within the burst
  function automatic logic [2:0] burst_low(input logic [2:0] s,
                                           input logic [2:0] idx,
                                           input logic       bl8,
                                           input logic       intl);
    logic [2:0] seq;
    seq = s + idx;
    if (intl) begin
      return bl8 ? (s ^ idx) : {s[2], s[1:0] ^ idx[1:0]};
    end
    return bl8 ? seq : {s[2], seq[1:0]};
  endfunction

  // ****************************************
  // Pin capture
  // ****************************************
  // Bus skew across the stages is tolerated: pins are held a full cycle
  scbfe_pins_t pin_raw;
  scbfe_pins_t p;
  assign pin_raw = {CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR,
                    DQS_T_IN, DQS_C_IN, DQ_RISE_IN, DQ_FALL_IN};

  scbfe_sync #(
    .W ($bits(scbfe_pins_t))
  ) u_pin_sync (
    .clk   (CLK),
    .reset (RESET),
    .ce    (CE),
    .d     (pin_raw),
    .q     (p)
  );

  // ****************************************
  // State
  // ****************************************
  scbfe_state_t     st_r;
  scbfe_state_t     st_nxt;
  scbfe_cmd_t       cmd;
  logic             run;
  logic             strobe_ok;
  logic             last;
  logic [LAT_W-1:0] cl;
  logic [LAT_W-1:0] al;
  logic [LAT_W-1:0] rl;

  assign cmd       = decode(p);
  assign run       = st_r.cke_last;
  assign strobe_ok = p.dqs_t & ~p.dqs_c;
  assign last      = st_r.beat == (st_r.bl8 ? LAST_BL8 : LAST_BL4);
  assign cl        = LAT_W'(CAS_LATENCY);

  // Additive latency choice; the unused code falls back to zero
  always_comb begin
    case (ADD_LAT_SEL)
      AL_CL_M1: al = cl - 5'h01;
      AL_CL_M2: al = cl - 5'h02;
      default:  al = 5'h00;
    endcase
    rl = cl + al;
  end

  // ****************************************
  // Next state
  // ****************************************
  // Everything but the enable history and the low-power flags waits while the clock is stopped
  always_comb begin
    st_nxt = st_r;
    if (run) begin
      case (cmd)
        CMD_ACT: st_nxt.bank_act[p.ba] = 1'b1;
        CMD_PRE: begin
          if (p.addr[AP_BIT]) begin
            st_nxt.bank_act = RST_BANKS;
          end else begin
            st_nxt.bank_act[p.ba] = 1'b0;
          end
        end
        CMD_RD, CMD_WR: begin
          if (st_r.phase == ST_IDLE && st_r.bank_act[p.ba]) begin
            st_nxt.phase = (cmd == CMD_RD) ? ST_RLAT : ST_WLAT;
            st_nxt.lat   = (cmd == CMD_RD) ? rl : rl - 5'h01;
            st_nxt.bank  = p.ba;
            st_nxt.col   = p.addr[COL_W-1:0];
            st_nxt.ap    = p.addr[AP_BIT];
            st_nxt.bl8   = BURST_LEN_8;
            st_nxt.intl  = BURST_INTERLEAVE;
            st_nxt.beat  = 2'h0;
          end
        end
        default: ;
      endcase
      case (st_r.phase)
        ST_RLAT, ST_WLAT: begin
          if (st_r.lat <= 5'h01) begin
            st_nxt.phase = (st_r.phase == ST_RLAT) ? ST_READ : ST_WRITE;
          end else begin
            st_nxt.lat = st_r.lat - 5'h01;
          end
        end
        ST_READ, ST_WRITE: begin
          // Writes advance only on a strobe from the controller
          if (st_r.phase == ST_READ || strobe_ok) begin
            if (last) begin
              st_nxt.phase = ST_IDLE;
              if (st_r.ap) st_nxt.bank_act[st_r.bank] = 1'b0;
            end else begin
              st_nxt.beat = st_r.beat + 2'h1;
            end
          end
        end
        default: ;
      endcase
      st_nxt.dq_drv = st_r.phase == ST_READ;
      st_nxt.dq_r   = ARR_RDATA_RISE;
      st_nxt.dq_f   = ARR_RDATA_FALL;
      // Idle banks turn a falling enable into a low-power entry
      if (!p.cke && st_r.bank_act == RST_BANKS
          && st_r.phase == ST_IDLE) begin
        st_nxt.pd = cmd != CMD_REF;
        st_nxt.sr = cmd == CMD_REF;
      end
    end else if (p.cke) begin
      st_nxt.pd = 1'b0;
      st_nxt.sr = 1'b0;
    end
    st_nxt.cke_last = p.cke;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_r          <= '0;
      st_r.cke_last <= RST_CKE;
      st_r.bank_act <= RST_BANKS;
      st_r.phase    <= ST_IDLE;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Column pair is a decode of held burst state, so it freezes with it
  assign ARR_BANK       = st_r.bank;
  assign ARR_COL_RISE   = {st_r.col[COL_W-1:3],
                           burst_low(st_r.col[2:0], {st_r.beat, 1'b0},
                                     st_r.bl8, st_r.intl)};
  assign ARR_COL_FALL   = {st_r.col[COL_W-1:3],
                           burst_low(st_r.col[2:0], {st_r.beat, 1'b1},
                                     st_r.bl8, st_r.intl)};
  assign ARR_RD         = run && st_r.phase == ST_READ;
  assign ARR_WR         = run && st_r.phase == ST_WRITE && strobe_ok;
  assign ARR_WDATA_RISE = p.dq_rise;
  assign ARR_WDATA_FALL = p.dq_fall;
  assign DQ_RISE_OUT    = st_r.dq_r;
  assign DQ_FALL_OUT    = st_r.dq_f;
  assign DQ_OE_N        = ~st_r.dq_drv;
  assign DQS_T_OUT      = st_r.dq_drv;
  assign DQS_C_OUT      = 1'b0;
  assign DQS_OE_N       = ~st_r.dq_drv;
  assign BANK_ACTIVE    = st_r.bank_act;
  assign POWER_DOWN     = st_r.pd;
  assign SELF_REFRESH   = st_r.sr;
  assign CLK_STOPPED    = ~st_r.cke_last;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_CS_MASK: assert property (CE && run && p.cs_n
    && st_r.phase == ST_IDLE
    |=> $stable(st_r.bank_act)) else $error("command taken with select high");
  AST_ACT_BANK: assert property (CE && run && cmd == CMD_ACT
    |=> st_r.bank_act[$past(p.ba)]) else $error("activate missed bank");
  AST_PRE_ALL: assert property (CE && run && cmd == CMD_PRE
    && p.addr[AP_BIT]
    |=> st_r.bank_act == RST_BANKS) else $error("all-bank precharge failed");
  AST_PRE_ONE: assert property (CE && run && cmd == CMD_PRE
    && !p.addr[AP_BIT] && st_r.phase == ST_IDLE
    |=> st_r.bank_act == ($past(st_r.bank_act)
        & ~(8'h01 << $past(p.ba)))) else $error("precharge hit wrong bank");
  AST_FREEZE: assert property (!run
    |=> $stable(st_r.col) && $stable(st_r.beat) && $stable(DQ_RISE_OUT)
        && $stable(st_r.bank_act)) else $error("state moved while stopped");
  AST_RUN: assert property (CE && p.cke |=> !CLK_STOPPED)
    else $error("clock not resumed");
  AST_PD_ENTRY: assert property (CE && run && !p.cke
    && st_r.bank_act == RST_BANKS && st_r.phase == ST_IDLE
    |=> POWER_DOWN ^ SELF_REFRESH) else $error("no low-power entry");
  AST_BURST_LEN: assert property (st_r.phase == ST_READ
    |-> st_r.beat <= (st_r.bl8 ? LAST_BL8 : LAST_BL4))
    else $error("burst ran too long");
  AST_DDR_OUT: assert property (CE && run && st_r.phase == ST_READ
    |=> !DQ_OE_N && DQ_RISE_OUT == $past(ARR_RDATA_RISE))
    else $error("read word not driven");
  AST_STROBE: assert property (DQ_OE_N == DQS_OE_N)
    else $error("strobe not paired with data");
  AST_ORDER: assert property (st_r.phase == ST_READ && st_r.intl
    |-> ARR_COL_FALL[2:0] == (ARR_COL_RISE[2:0] ^ 3'h1))
    else $error("interleave order wrong");
  AST_AL: assert property (CE && run && cmd == CMD_RD
    && st_r.phase == ST_IDLE && st_r.bank_act[p.ba]
    |=> st_r.lat == $past(rl) && st_r.phase == ST_RLAT)
    else $error("read latency not loaded");

endmodule // scbfe_front_end
`default_nettype wire

// ---- design/scbfe_pkg.sv ----
`default_nettype none
package scbfe_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_BANKS = 8;
  localparam int BA_W      = 3;
  localparam int ADDR_W    = 13;
  localparam int COL_W     = 10;
  localparam int DQ_W      = 16;
  localparam int CL_W      = 4;
  localparam int LAT_W     = 5;
  localparam int AP_BIT    = 10;

  // ****************************************
  // Latency and burst encodings
  // ****************************************
  localparam logic [1:0] AL_ZERO   = 2'h0;
  localparam logic [1:0] AL_CL_M1  = 2'h1;
  localparam logic [1:0] AL_CL_M2  = 2'h2;
  localparam logic [1:0] LAST_BL4  = 2'h1;  // Last beat pair, 4 words
  localparam logic [1:0] LAST_BL8  = 2'h3;  // Last beat pair, 8 words

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [NUM_BANKS-1:0] RST_BANKS = 8'h00;
  localparam logic                 RST_CKE   = 1'b0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_REF, CMD_OTHER
  } scbfe_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RLAT, ST_WLAT, ST_READ, ST_WRITE
  } scbfe_phase_t;

  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic              dqs_t;
    logic              dqs_c;
    logic [DQ_W-1:0]   dq_rise;
    logic [DQ_W-1:0]   dq_fall;
  } scbfe_pins_t;

  typedef struct packed {
    logic                 cke_last;
    logic [NUM_BANKS-1:0] bank_act;
    scbfe_phase_t         phase;
    logic [LAT_W-1:0]     lat;
    logic [1:0]           beat;
    logic [BA_W-1:0]      bank;
    logic [COL_W-1:0]     col;
    logic                 ap;
    logic                 bl8;
    logic                 intl;
    logic                 pd;
    logic                 sr;
    logic                 dq_drv;
    logic [DQ_W-1:0]      dq_r;
    logic [DQ_W-1:0]      dq_f;
  } scbfe_state_t;

endpackage
`default_nettype wire

// ---- design/scbfe_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module scbfe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } scbfe_sync_st_t;

  scbfe_sync_st_t st_r;
  scbfe_sync_st_t st_nxt;

  // ****************************************
  // Two-stage capture on the rising edge
  // ****************************************
  // Only the second stage is visible; the first may be metastable
  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta   = d;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stable;

endmodule // scbfe_sync
`default_nettype wire

// ---- verif/scbfe_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ******
// Array stand-in
// ******
module scbfe_array_model
  import scbfe_pkg::*;
(
  input  wire logic [BA_W-1:0]  bank,
  input  wire logic [COL_W-1:0] col_r,
  input  wire logic [COL_W-1:0] col_f,
  input  wire logic             rd,
  output logic      [DQ_W-1:0]  q_r,
  output logic      [DQ_W-1:0]  q_f
);
  // Word names bank and column, so misrouting shows
  // Idle bus shows the inverse, never a stale word
  always_comb begin
    q_r = {bank, 3'h0, col_r};
    q_f = {bank, 3'h0, col_f};
    if (!rd) begin
      q_r = ~q_r;
      q_f = ~q_f;
    end
  end
endmodule // scbfe_array_model
`default_nettype wire

// ---- verif/sdram_clock_bank_front_end_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdram_clock_bank_front_end_tb_top
  import scbfe_pkg::*;
;
  logic                 CLK, RESET, CE, CKE, CS_N, RAS_N, CAS_N, WE_N;
  logic                 DQS_T_IN, DQS_C_IN, BURST_LEN_8, BURST_INTERLEAVE;
  logic                 ARR_RD, ARR_WR, DQ_OE_N, DQS_T_OUT, DQS_C_OUT;
  logic                 DQS_OE_N, POWER_DOWN, SELF_REFRESH, CLK_STOPPED;
  logic [BA_W-1:0]      BA, ARR_BANK;
  logic [ADDR_W-1:0]    ADDR;
  logic [COL_W-1:0]     ARR_COL_RISE, ARR_COL_FALL;
  logic [CL_W-1:0]      CAS_LATENCY;
  logic [1:0]           ADD_LAT_SEL;
  logic [NUM_BANKS-1:0] BANK_ACTIVE;
  logic [DQ_W-1:0]      DQ_RISE_IN, DQ_FALL_IN, ARR_RDATA_RISE;
  logic [DQ_W-1:0]      ARR_RDATA_FALL, ARR_WDATA_RISE, ARR_WDATA_FALL;
  logic [DQ_W-1:0]      DQ_RISE_OUT, DQ_FALL_OUT;
  int                   err_total, compares, n, w, rl;

  // ******
  // Design and array model
  // ******
  scbfe_front_end uut (
    .CLK, .RESET, .CE, .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N, .BA, .ADDR,
    .DQS_T_IN, .DQS_C_IN, .DQ_RISE_IN, .DQ_FALL_IN, .BURST_LEN_8,
    .BURST_INTERLEAVE, .CAS_LATENCY, .ADD_LAT_SEL, .ARR_RDATA_RISE,
    .ARR_RDATA_FALL, .ARR_RD, .ARR_WR, .ARR_BANK, .ARR_COL_RISE,
    .ARR_COL_FALL, .ARR_WDATA_RISE, .ARR_WDATA_FALL, .DQ_RISE_OUT,
    .DQ_FALL_OUT, .DQ_OE_N, .DQS_T_OUT, .DQS_C_OUT, .DQS_OE_N,
    .BANK_ACTIVE, .POWER_DOWN, .SELF_REFRESH, .CLK_STOPPED
  );
  scbfe_array_model array_i (
    .bank(ARR_BANK), .col_r(ARR_COL_RISE), .col_f(ARR_COL_FALL),
    .rd(ARR_RD), .q_r(ARR_RDATA_RISE), .q_f(ARR_RDATA_FALL)
  );

  // 100 MHz clock
  always #5 CLK = ~CLK;

  // ******
  // Tasks
  // ******
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Sample 1 ns after the edge so edge updates have landed
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask

  // One command cycle, then deselect; clock enable follows k
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                     input logic [12:0] a, input logic k);
    @(posedge CLK);
    {CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR} <= {k, c, b, a};
    @(posedge CLK);
    {CS_N, RAS_N, CAS_N, WE_N} <= 4'hF;
  endtask

  // Column of word k in a burst; short bursts keep bit 2
  function automatic logic [9:0] bc(input logic [9:0] c, input logic b8,
                                    input logic il, input logic [2:0] k);
    logic [2:0] m;
    logic [2:0] l;
    m = b8 ? 3'h7 : 3'h3;
    l = il ? (c[2:0] ^ k) : (c[2:0] + k);
    return {c[9:3], (c[2:0] & ~m) | (l & m)};
  endfunction

  task automatic results();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cut a hang short; the tests need about 250 cycles
  initial begin
    #100000;
    err_total++;
    results();
  end

  // ******
  // Test sequence
  // ******
  initial begin
    {CLK, RESET, CE, CKE, CS_N, RAS_N, CAS_N, WE_N} = 8'h7F;
    {BA, ADDR, DQ_RISE_IN, DQ_FALL_IN} = '0;
    {DQS_T_IN, DQS_C_IN, BURST_LEN_8, BURST_INTERLEAVE, ADD_LAT_SEL} = 6'h10;
    CAS_LATENCY = 4'h5;
    err_total = 0;
    compares = 0;
    tick(15);
    chk({DQ_OE_N, DQS_OE_N, CLK_STOPPED, BANK_ACTIVE}, 11'h700);
    @(posedge CLK);
    RESET <= 1'b0;
    CKE <= 1'b1;
    tick(6);
    chk(CLK_STOPPED, 1'b0);
    $display("test reset done");
    cmd(4'hB, 3'h0, 13'h0000, 1'b1);
    tick(3);
    chk(BANK_ACTIVE, 8'h00);
    for (int b = 0; b < 8; b++) begin
      cmd(4'h3, b[2:0], 13'h0000, 1'b1);
      tick(3);
      chk(BANK_ACTIVE, (9'h002 << b) - 9'h001);
    end
    cmd(4'h2, 3'h3, 13'h0000, 1'b1);
    tick(3);
    chk(BANK_ACTIVE, 8'hF7);
    cmd(4'h2, 3'h0, 13'h0400, 1'b1);
    tick(3);
    chk(BANK_ACTIVE, 8'h00);
    $display("test banks done");
    // Every latency code and burst mode; last read auto-precharges
    cmd(4'h3, 3'h5, 13'h0000, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      ADD_LAT_SEL <= i[1:0];
      BURST_LEN_8 <= i[0];
      BURST_INTERLEAVE <= i[1];
      rl = (i == 1) ? 9 : (i == 2) ? 8 : 5;
      cmd(4'h5, 3'h5, {2'h0, i == 3, 10'h2D5}, 1'b1);
      n = 0;
      while (DQ_OE_N !== 1'b0 && n < 40) begin
        tick(1);
        n++;
      end
      chk(n, rl + 3);
      chk(ARR_RD, 1'b1);
      for (int j = 0; j < (i[0] ? 8 : 4); j += 2) begin
        chk({DQ_RISE_OUT, DQ_FALL_OUT}, {6'h28, bc(10'h2D5, i[0], i[1],
            j[2:0]), 6'h28, bc(10'h2D5, i[0], i[1], j[2:0] + 3'h1)});
        chk({DQS_OE_N, DQS_T_OUT, DQS_C_OUT}, 3'h2);
        tick(1);
      end
      chk({DQ_OE_N, ARR_RD}, 2'h2);
    end
    tick(2);
    chk(BANK_ACTIVE, 8'h00);
    $display("test reads done");
    cmd(4'h5, 3'h6, 13'h0000, 1'b1);
    n = 0;
    repeat (20) begin
      tick(1);
      if (DQ_OE_N !== 1'b1) n++;
    end
    chk(n, 0);
    $display("test closed bank done");
    cmd(4'h3, 3'h2, 13'h0000, 1'b1);
    BURST_LEN_8 <= 1'b1;
    BURST_INTERLEAVE <= 1'b0;
    cmd(4'h4, 3'h2, 13'h0013, 1'b1);
    {DQS_T_IN, DQS_C_IN, DQ_RISE_IN, DQ_FALL_IN} <= 34'h2_1234_5678;
    w = 0;
    repeat (30) begin
      tick(1);
      if (ARR_WR === 1'b1) begin
        chk({ARR_BANK, ARR_COL_RISE, ARR_COL_FALL}, {3'h2, bc(10'h013,
            1'b1, 1'b0, 3'(2 * w)), bc(10'h013, 1'b1, 1'b0,
            3'(2 * w + 1))});
        chk({ARR_WDATA_RISE, ARR_WDATA_FALL}, 32'h12345678);
        w++;
      end
    end
    chk(w, 4);
    @(posedge CLK);
    {DQS_T_IN, DQS_C_IN, DQ_RISE_IN, DQ_FALL_IN} <= 34'h1_EDCB_A987;
    $display("test write done");
    // Low-power entry only with all banks closed
    cmd(4'h2, 3'h0, 13'h0400, 1'b1);
    tick(3);
    cmd(4'h7, 3'h0, 13'h0000, 1'b0);
    tick(4);
    chk({POWER_DOWN, SELF_REFRESH, CLK_STOPPED}, 3'h5);
    cmd(4'h3, 3'h1, 13'h0000, 1'b0);
    tick(3);
    chk(BANK_ACTIVE, 8'h00);
    cmd(4'h7, 3'h0, 13'h0000, 1'b1);
    tick(5);
    chk({POWER_DOWN, SELF_REFRESH, CLK_STOPPED}, 3'h0);
    cmd(4'h1, 3'h0, 13'h0000, 1'b0);
    tick(4);
    chk({POWER_DOWN, SELF_REFRESH, CLK_STOPPED}, 3'h3);
    cmd(4'h7, 3'h0, 13'h0000, 1'b1);
    tick(5);
    chk({POWER_DOWN, SELF_REFRESH, CLK_STOPPED}, 3'h0);
    $display("test low power done");
    // Enable low drops a command on the pins
    @(posedge CLK);
    CE <= 1'b0;
    cmd(4'h3, 3'h4, 13'h0000, 1'b1);
    tick(3);
    @(posedge CLK);
    CE <= 1'b1;
    tick(4);
    chk(BANK_ACTIVE, 8'h00);
    $display("test enable done");
    results();
  end
endmodule // sdram_clock_bank_front_end_tb_top
`default_nettype wire
